// File: verilog/acl_pkg.sv
package acl_pkg;

    // model-specific register addresses (64-bit registers)
    localparam logic [31:0] ACL_MSR_TRAP_ADDR   = 32'h51500002;
    localparam logic [31:0] ACL_MSR_ERROR_ADDR  = 32'h51500003;
    localparam logic [31:0] ACL_MSR_CLKGATE_ADDR = 32'h51500004;
    localparam logic [31:0] ACL_MSR_DIAG_ADDR   = 32'h51500005;

    // i/o offsets (32-bit registers)
    localparam logic [7:0]  ACL_IO_GPIO_STATE   = 8'h00;
    localparam logic [7:0]  ACL_IO_GPIO_DRIVE   = 8'h04;
    localparam logic [7:0]  ACL_IO_LINK_STATE   = 8'h08;

    // reset values
    localparam logic [63:0] ACL_MSR_RESET       = 64'h0000000000000000;
    localparam logic [31:0] ACL_IO_RESET        = 32'h00000000;

    // trap and error control fields
    localparam int ACL_FLAG_BIT          = 32;
    localparam int ACL_ENABLE_BIT        = 0;

    // clock gating fields
    localparam int ACL_LB_GATE_LSB       = 2;
    localparam int ACL_IC_GATE_LSB       = 0;
    localparam int ACL_PM_KEEP_LSB       = 62;
    localparam logic [1:0] ACL_GATE_ALWAYS_ON = 2'h0;
    localparam logic [1:0] ACL_GATE_WHEN_IDLE = 2'h1;

    // codec gpio state fields
    localparam int ACL_GPIO_OUT_EN_BIT   = 31;
    localparam int ACL_GPIO_INT_EN_BIT   = 30;
    localparam int ACL_WAKE_EN_BIT       = 29;
    localparam int ACL_GPIO_FLAG_BIT     = 21;
    localparam int ACL_WAKE_FLAG_BIT     = 20;
    localparam int ACL_SLOT_W            = 20;

    // codec link state fields
    localparam int ACL_ADDR_LSB          = 24;
    localparam int ACL_PRIM_RDY_BIT      = 23;
    localparam int ACL_SEC_RDY_BIT       = 22;
    localparam int ACL_SEC_IN_EN_BIT     = 21;
    localparam int ACL_IN_SEL_BIT        = 20;
    localparam int ACL_OUT_SEL_BIT       = 19;
    localparam int ACL_FRESH_BIT         = 17;

    // frame tag bits and slot numbers
    localparam int ACL_TAG_READY_BIT     = 15;
    localparam int ACL_TAG_SLOT1_BIT     = 14;
    localparam int ACL_TAG_SLOT2_BIT     = 13;
    localparam int ACL_TAG_SLOT12_BIT    = 3;
    localparam int ACL_TAG_W             = 16;
    localparam logic [3:0] ACL_SLOT_A    = 4'h6;
    localparam logic [3:0] ACL_SLOT_B    = 4'hB;

endpackage

// File: verilog/acl_link_rx.sv
`timescale 1ns/100ps
`default_nettype none
// link-side frame receiver, clocked by the codec bit clock
module acl_link_rx
    import acl_pkg::*;
(
    // clock and reset
    input  wire logic                link_clk_i,
    input  wire logic                resetn_i,
    // link pins
    input  wire logic                sync_i,
    input  wire logic                serial_in_primary_i,
    input  wire logic                serial_in_secondary_i,
    // captured frame words; slot 12 changes with the toggle, tag and slots 1 and 2 early in the next frame
    output logic                     frame_toggle_o,
    output logic [ACL_TAG_W-1:0]     tag_o,
    output logic                     sec_ready_o,
    output logic [ACL_SLOT_W-1:0]    slot1_o,
    output logic [ACL_SLOT_W-1:0]    slot2_o,
    output logic [ACL_SLOT_W-1:0]    slot12_o
);

    // all state of the receiver
    typedef struct packed {
        logic                  sync_prev;   // sync seen last bit
        logic [7:0]            bit_cnt;     // bit position in frame
        logic [ACL_SLOT_W-1:0] shift;       // serial shift register
        logic                  sec_first;   // first bit of secondary stream
        logic [ACL_TAG_W-1:0]  tag;
        logic                  sec_rdy;
        logic [ACL_SLOT_W-1:0] s1;
        logic [ACL_SLOT_W-1:0] s2;
        logic [ACL_SLOT_W-1:0] s12;
        logic                  tog;         // flips once per finished frame
    } acl_rx_t;

    acl_rx_t st_q;
    acl_rx_t st_d;

    // slot end positions, counted from the first bit of the tag slot
    function automatic logic [7:0] slot_end(input int n);
        slot_end = 8'((ACL_TAG_W - 1) + ACL_SLOT_W * n);
    endfunction

    // next-state: shift one bit, capture words at slot boundaries
    always_comb begin
        logic [ACL_SLOT_W-1:0] word;
        word = {st_q.shift[ACL_SLOT_W-2:0], serial_in_primary_i};
        st_d = st_q;
        st_d.sync_prev = sync_i;
        st_d.shift = word;
        if (sync_i && !st_q.sync_prev) begin
            // frame start: this bit is bit 0 of the tag slot
            st_d.bit_cnt = 8'h00;
            st_d.sec_first = serial_in_secondary_i;
        end else if (st_q.bit_cnt != slot_end(12)) begin
            // park after the last slot: a free-running bit clock must not wrap into a phantom frame
            st_d.bit_cnt = st_q.bit_cnt + 8'h01;
        end
        if (st_d.bit_cnt == slot_end(0)) begin
            st_d.tag = word[ACL_TAG_W-1:0];
            st_d.sec_rdy = st_q.sec_first;
        end
        if (st_d.bit_cnt == slot_end(1)) begin
            st_d.s1 = word;
        end
        if (st_d.bit_cnt == slot_end(2)) begin
            st_d.s2 = word;
        end
        if (st_d.bit_cnt == slot_end(12) && st_q.bit_cnt != slot_end(12)) begin
            // last slot: hand the frame over to the register side
            st_d.s12 = word;
            st_d.tog = !st_q.tog;
        end
    end

    // state register; the bit clock may stop, nothing here waits on it
    always_ff @(posedge link_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign frame_toggle_o = st_q.tog;
    assign tag_o          = st_q.tag;
    assign sec_ready_o    = st_q.sec_rdy;
    assign slot1_o        = st_q.s1;
    assign slot2_o        = st_q.s2;
    assign slot12_o       = st_q.s12;

endmodule
`default_nettype wire

// File: verilog/acl_gpio_status.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - trap flag sets on controller interrupt rise
// - write one clears trap flag, zero keeps
// - trap flag and trap only when enabled
// - bad type or exception sets error flag
// - error flag and report only when enabled
// - local bus gating: 00 on, 01 idle-off
// - interconnect gating: 00 on, 01 idle-off
// - slot 12 out enable: zeros invalid, else valid
// - gpio interrupt bit sets gpio flag, irq
// - wakeup edge while powered down sets flag
// - reading gpio status clears both flags
// - valid input slot 12 copied to snapshot
// - output slot 12 driven from drive value
// - slot 1 bits 19:12 into address field
// - ready bits follow slot 0 bit 15
// - link shutdown clears both ready bits
// - second input anded with its enable
// - input slot choice: slot 6 or 11
// - output slot choice: slot 6 or 11
// - valid slot 2 latches value, sets fresh
module acl_gpio_status
    import acl_pkg::*;
(
    // register-side clock and reset
    input  wire logic                clock_i,
    input  wire logic                resetn_i,
    // model-specific register access
    input  wire logic [31:0]         msr_addr_i,
    input  wire logic                msr_wr_i,
    input  wire logic                msr_rd_i,
    input  wire logic [63:0]         msr_wdata_i,
    output logic [63:0]              msr_rdata_o,
    // i/o register access
    input  wire logic [7:0]          io_addr_i,
    input  wire logic                io_wr_i,
    input  wire logic                io_rd_i,
    input  wire logic [31:0]         io_wdata_i,
    output logic [31:0]              io_rdata_o,
    // serial link, bit clock domain
    input  wire logic                link_clk_i,
    input  wire logic                sync_i,
    input  wire logic                serial_in_primary_i,
    input  wire logic                serial_in_secondary_i,
    // controller status inputs
    input  wire logic                link_shutdown_set_i,
    input  wire logic                codecs_powered_down_i,
    input  wire logic                other_irq_i,
    input  wire logic                bad_type_event_i,
    input  wire logic                resp_valid_i,
    input  wire logic                exception_bit_i,
    input  wire logic                local_bus_idle_i,
    input  wire logic                interconnect_idle_i,
    // event outputs
    output logic                     irq_o,
    output logic                     sync_mgmt_trap_o,
    output logic                     error_o,
    // clock gate requests
    output logic                     local_bus_clk_off_o,
    output logic                     interconnect_clk_off_o,
    // outgoing slot 12 and bus master slot routing
    output logic [ACL_SLOT_W-1:0]    out_slot12_data_o,
    output logic                     out_slot12_valid_o,
    output logic [3:0]               bm5_rx_slot_o,
    output logic [3:0]               bm4_tx_slot_o
);

    // frame words handed over from the bit clock domain
    logic                  rx_tog;
    logic [ACL_TAG_W-1:0]  rx_tag;
    logic                  rx_sec_rdy;
    logic [ACL_SLOT_W-1:0] rx_s1;
    logic [ACL_SLOT_W-1:0] rx_s2;
    logic [ACL_SLOT_W-1:0] rx_s12;

    // receiver on the link's own clock
    acl_link_rx u_rx (
        .link_clk_i            (link_clk_i),
        .resetn_i              (resetn_i),
        .sync_i                (sync_i),
        .serial_in_primary_i   (serial_in_primary_i),
        .serial_in_secondary_i (serial_in_secondary_i),
        .frame_toggle_o        (rx_tog),
        .tag_o                 (rx_tag),
        .sec_ready_o           (rx_sec_rdy),
        .slot1_o               (rx_s1),
        .slot2_o               (rx_s2),
        .slot12_o              (rx_s12)
    );

    // all register-side state
    typedef struct packed {
        // trap, error, gating, diagnostic control words
        logic                  trap_en;
        logic                  trap_flag;
        logic                  trap_pulse;
        logic                  err_en;
        logic                  err_flag;
        logic                  err_pulse;
        logic [1:0]            pm_keep;     // upper bits that read back
        logic [1:0]            lb_gate;
        logic [1:0]            ic_gate;
        logic [63:0]           diag;
        // codec gpio state and drive
        logic                  gpio_out_en;
        logic                  gpio_int_en;
        logic                  wake_en;
        logic                  gpio_flag;
        logic                  wake_flag;
        logic [ACL_SLOT_W-1:0] pin_snap;
        logic [ACL_SLOT_W-1:0] gpio_drive;
        // codec link state
        logic [7:0]            ret_addr;
        logic                  prim_rdy;
        logic                  sec_rdy;
        logic                  sec_in_en;
        logic                  in_sel;
        logic                  out_sel;
        logic                  fresh;
        logic [15:0]           ret_value;
        // interrupt line and its previous level
        logic                  irq;
        logic                  irq_prev;
        // synchronisers: frame toggle and both serial inputs
        logic                  tog_s1;
        logic                  tog_s2;
        logic                  tog_s3;
        logic                  sin1_s1;
        logic                  sin1_s2;
        logic                  sin1_prev;
        logic                  sin2_s1;
        logic                  sin2_s2;
        logic                  sin2_prev;
        // registered read data
        logic [63:0]           msr_rdata;
        logic [31:0]           io_rdata;
    } acl_state_t;

    acl_state_t st_q;
    acl_state_t st_d;

    // slot number for a choice bit, shared by both bus masters
    function automatic logic [3:0] slot_for(input logic choice);
        slot_for = choice ? ACL_SLOT_B : ACL_SLOT_A;
    endfunction

    // a gating field requests the clock off only in its idle-off code;
    // reserved codes behave like always-on so a bad write stays safe
    function automatic logic gate_off(input logic [1:0] mode, input logic idle);
        gate_off = (mode == ACL_GATE_WHEN_IDLE) && idle;
    endfunction

    // next-state logic
    always_comb begin
        logic frame_evt;      // a new frame reached this domain
        logic sin2_gated;     // second input after its enable
        logic wake_evt;
        logic gpio_evt;
        logic err_evt;
        logic irq_rise;
        logic gpio_state_rd;
        logic link_state_rd;
        logic [31:0] gpio_state_word;
        logic [31:0] link_state_word;
        frame_evt = 1'b0;
        sin2_gated = 1'b0;
        wake_evt = 1'b0;
        gpio_evt = 1'b0;
        err_evt = 1'b0;
        irq_rise = 1'b0;
        gpio_state_rd = 1'b0;
        link_state_rd = 1'b0;
        gpio_state_word = '0;
        link_state_word = '0;
        st_d = st_q;

        // two flops per crossing before any logic looks at the level
        st_d.tog_s1 = rx_tog;
        st_d.tog_s2 = st_q.tog_s1;
        st_d.tog_s3 = st_q.tog_s2;
        st_d.sin1_s1 = serial_in_primary_i;
        st_d.sin1_s2 = st_q.sin1_s1;
        st_d.sin2_s1 = serial_in_secondary_i;
        st_d.sin2_s2 = st_q.sin2_s1;

        // frame words were written no later than the toggle flip and stay put until the next frame's tag slot ends,
        // so they are sampled safely once the toggle has crossed
        frame_evt = st_q.tog_s2 ^ st_q.tog_s3;
        sin2_gated = st_q.sin2_s2 & st_q.sec_in_en;
        st_d.sin1_prev = st_q.sin1_s2;
        st_d.sin2_prev = sin2_gated;

        // event detection
        wake_evt = codecs_powered_down_i && st_q.wake_en &&
                   ((st_q.sin1_s2 && !st_q.sin1_prev) ||
                    (sin2_gated && !st_q.sin2_prev));
        gpio_evt = frame_evt && st_q.gpio_int_en &&
                   rx_tag[ACL_TAG_SLOT12_BIT] && rx_s12[0];
        err_evt = st_q.err_en &&
                  (bad_type_event_i || (resp_valid_i && exception_bit_i));
        irq_rise = st_q.irq && !st_q.irq_prev;
        gpio_state_rd = io_rd_i && (io_addr_i == ACL_IO_GPIO_STATE);
        link_state_rd = io_rd_i && (io_addr_i == ACL_IO_LINK_STATE);

        // ---- model-specific register writes ----
        if (msr_wr_i) begin
            case (msr_addr_i)
                ACL_MSR_TRAP_ADDR: begin
                    st_d.trap_en = msr_wdata_i[ACL_ENABLE_BIT];
                    if (msr_wdata_i[ACL_FLAG_BIT]) begin
                        st_d.trap_flag = 1'b0;
                    end
                end
                ACL_MSR_ERROR_ADDR: begin
                    st_d.err_en = msr_wdata_i[ACL_ENABLE_BIT];
                    if (msr_wdata_i[ACL_FLAG_BIT]) begin
                        st_d.err_flag = 1'b0;
                    end
                end
                ACL_MSR_CLKGATE_ADDR: begin
                    st_d.pm_keep = msr_wdata_i[ACL_PM_KEEP_LSB +: 2];
                    st_d.lb_gate = msr_wdata_i[ACL_LB_GATE_LSB +: 2];
                    st_d.ic_gate = msr_wdata_i[ACL_IC_GATE_LSB +: 2];
                end
                ACL_MSR_DIAG_ADDR: begin
                    st_d.diag = msr_wdata_i;
                end
                default: begin
                    // unmapped: write ignored
                end
            endcase
        end

        // ---- i/o register writes ----
        if (io_wr_i) begin
            case (io_addr_i)
                ACL_IO_GPIO_STATE: begin
                    st_d.gpio_out_en = io_wdata_i[ACL_GPIO_OUT_EN_BIT];
                    st_d.gpio_int_en = io_wdata_i[ACL_GPIO_INT_EN_BIT];
                    st_d.wake_en = io_wdata_i[ACL_WAKE_EN_BIT];
                end
                ACL_IO_GPIO_DRIVE: begin
                    st_d.gpio_drive = io_wdata_i[ACL_SLOT_W-1:0];
                end
                ACL_IO_LINK_STATE: begin
                    st_d.sec_in_en = io_wdata_i[ACL_SEC_IN_EN_BIT];
                    st_d.in_sel = io_wdata_i[ACL_IN_SEL_BIT];
                    st_d.out_sel = io_wdata_i[ACL_OUT_SEL_BIT];
                end
                default: begin
                    // read-only or unmapped offset
                end
            endcase
        end

        // read side effects come before sets, so an event in the
        // same cycle survives the read
        if (gpio_state_rd) begin
            st_d.gpio_flag = 1'b0;
            st_d.wake_flag = 1'b0;
        end
        if (link_state_rd) begin
            st_d.fresh = 1'b0;
        end
        if (link_shutdown_set_i) begin
            st_d.prim_rdy = 1'b0;
            st_d.sec_rdy = 1'b0;
        end

        // ---- hardware sets ----
        if (gpio_evt) begin
            st_d.gpio_flag = 1'b1;
        end
        if (wake_evt) begin
            st_d.wake_flag = 1'b1;
        end
        if (frame_evt) begin
            // primary ready follows every received tag slot; secondary ready only while its input is enabled
            st_d.prim_rdy = rx_tag[ACL_TAG_READY_BIT];
            if (st_q.sec_in_en) begin
                st_d.sec_rdy = rx_sec_rdy;
            end
            if (rx_tag[ACL_TAG_SLOT12_BIT]) begin
                st_d.pin_snap = rx_s12;
            end
            if (rx_tag[ACL_TAG_SLOT1_BIT]) begin
                st_d.ret_addr = rx_s1[ACL_SLOT_W-1 -: 8];
            end
            if (rx_tag[ACL_TAG_SLOT2_BIT]) begin
                st_d.ret_value = rx_s2[ACL_SLOT_W-1 -: 16];
                st_d.fresh = 1'b1;
            end
        end

        // interrupt line held while any source is pending
        st_d.irq = st_q.gpio_flag || st_q.wake_flag || other_irq_i;
        st_d.irq_prev = st_q.irq;

        // trap on the rising edge only; falling edge leaves the flag
        st_d.trap_pulse = irq_rise && st_q.trap_en;
        if (irq_rise && st_q.trap_en) begin
            st_d.trap_flag = 1'b1;
        end
        st_d.err_pulse = err_evt;
        if (err_evt) begin
            st_d.err_flag = 1'b1;
        end

        // ---- read data, one cycle after the strobe ----
        gpio_state_word = {st_q.gpio_out_en, st_q.gpio_int_en, st_q.wake_en,
                           7'h00, st_q.gpio_flag, st_q.wake_flag,
                           st_q.pin_snap};
        link_state_word = {st_q.ret_addr, st_q.prim_rdy, st_q.sec_rdy,
                           st_q.sec_in_en, st_q.in_sel, st_q.out_sel,
                           1'b0, st_q.fresh, 1'b0, st_q.ret_value};
        st_d.msr_rdata = ACL_MSR_RESET;
        if (msr_rd_i) begin
            case (msr_addr_i)
                ACL_MSR_TRAP_ADDR: begin
                    st_d.msr_rdata[ACL_FLAG_BIT] = st_q.trap_flag;
                    st_d.msr_rdata[ACL_ENABLE_BIT] = st_q.trap_en;
                end
                ACL_MSR_ERROR_ADDR: begin
                    st_d.msr_rdata[ACL_FLAG_BIT] = st_q.err_flag;
                    st_d.msr_rdata[ACL_ENABLE_BIT] = st_q.err_en;
                end
                ACL_MSR_CLKGATE_ADDR: begin
                    st_d.msr_rdata[ACL_PM_KEEP_LSB +: 2] = st_q.pm_keep;
                    st_d.msr_rdata[ACL_LB_GATE_LSB +: 2] = st_q.lb_gate;
                    st_d.msr_rdata[ACL_IC_GATE_LSB +: 2] = st_q.ic_gate;
                end
                ACL_MSR_DIAG_ADDR: begin
                    st_d.msr_rdata = st_q.diag;
                end
                default: begin
                    // unmapped reads return zero
                end
            endcase
        end
        st_d.io_rdata = ACL_IO_RESET;
        if (io_rd_i) begin
            case (io_addr_i)
                ACL_IO_GPIO_STATE: begin
                    st_d.io_rdata = gpio_state_word;
                end
                ACL_IO_GPIO_DRIVE: begin
                    st_d.io_rdata = {12'h000, st_q.gpio_drive};
                end
                ACL_IO_LINK_STATE: begin
                    st_d.io_rdata = link_state_word;
                end
                default: begin
                    // unmapped reads return zero
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // read data straight from registers
    assign msr_rdata_o = st_q.msr_rdata;
    assign io_rdata_o  = st_q.io_rdata;

    // events
    assign irq_o            = st_q.irq;
    assign sync_mgmt_trap_o = st_q.trap_pulse;
    assign error_o          = st_q.err_pulse;

    // clock gate requests; gates themselves sit outside this block
    assign local_bus_clk_off_o    = gate_off(st_q.lb_gate, local_bus_idle_i);
    assign interconnect_clk_off_o = gate_off(st_q.ic_gate, interconnect_idle_i);

    // outgoing slot 12: zeros and invalid tag while disabled,
    // reserved bits go out exactly as software wrote them
    assign out_slot12_data_o  = st_q.gpio_out_en ? st_q.gpio_drive : '0;
    assign out_slot12_valid_o = st_q.gpio_out_en;

    // bus master slot routing
    assign bm5_rx_slot_o = slot_for(st_q.in_sel);
    assign bm4_tx_slot_o = slot_for(st_q.out_sel);

endmodule
`default_nettype wire

// File: verif/acl_gpio_status_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// port watcher
module acl_gpio_status_monitor
    import acl_pkg::*;
(
    // clock, reset and event inputs
    input wire logic clock_i, resetn_i, io_wr_i, bad_type_event_i, resp_valid_i, exception_bit_i,
    input wire logic other_irq_i, local_bus_idle_i, interconnect_idle_i,
    input wire logic [7:0]            io_addr_i,
    input wire logic [31:0]           io_wdata_i,
    // watched outputs
    input wire logic irq_o, error_o, sync_mgmt_trap_o, local_bus_clk_off_o, interconnect_clk_off_o,
    input wire logic                  out_slot12_valid_o,
    input wire logic [ACL_SLOT_W-1:0] out_slot12_data_o,
    input wire logic [3:0]            bm5_rx_slot_o, bm4_tx_slot_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // steering writes
    sequence link_wr; io_wr_i && io_addr_i == ACL_IO_LINK_STATE; endsequence
    sequence gpio_wr; io_wr_i && io_addr_i == ACL_IO_GPIO_STATE; endsequence
    // level held two cycles
    sequence other_held; other_irq_i ##1 other_irq_i; endsequence
    in_slot_a: assert property (link_wr |=> bm5_rx_slot_o == ($past(io_wdata_i[20]) ? ACL_SLOT_B : ACL_SLOT_A))
        else $error("input slot choice not applied");
    out_slot_a: assert property (link_wr |=> bm4_tx_slot_o == ($past(io_wdata_i[19]) ? ACL_SLOT_B : ACL_SLOT_A))
        else $error("output slot choice not applied");
    slot_valid_a: assert property (gpio_wr |=> out_slot12_valid_o == $past(io_wdata_i[31]))
        else $error("slot 12 tag off");
    slot_zero_a: assert property (!out_slot12_valid_o |-> out_slot12_data_o == '0)
        else $error("slot 12 data while off");
    lb_gate_a: assert property (local_bus_clk_off_o |-> local_bus_idle_i)
        else $error("local bus gated while busy");
    ic_gate_a: assert property (interconnect_clk_off_o |-> interconnect_idle_i)
        else $error("interconnect gated while busy");
    trap_pulse_a: assert property (sync_mgmt_trap_o |=> !sync_mgmt_trap_o)
        else $error("trap longer than one cycle");
    err_cause_a: assert property (error_o |-> $past(bad_type_event_i || resp_valid_i && exception_bit_i))
        else $error("error without cause");
    irq_hold_a: assert property (other_held |-> irq_o)
        else $error("interrupt request not held");
endmodule
bind acl_gpio_status acl_gpio_status_monitor acl_gpio_status_monitor_i (.*);
`default_nettype wire

// File: verif/acl_codec_model.sv
`timescale 1ns/100ps
`default_nettype none
// codec: one 256-bit frame per go, msb first
module acl_codec_model (
    input  wire logic         link_clk_i,
    input  wire logic         go_i,
    input  wire logic [255:0] frame_i,
    output logic              sync_o = 1'b0,
    output logic              sdata_o = 1'b0
);
    int n = 0; // bits left in the frame
    // falling edge drive: bits settle before sampling
    always @(negedge link_clk_i) begin
        if (n == 0 && go_i)
            n = 256;
        sync_o <= n > 240; // sync covers the tag slot
        sdata_o <= (n > 0) ? frame_i[n-1] : 1'b0; // idle line rests at its pull-down
        if (n > 0)
            n = n - 1;
    end
endmodule
`default_nettype wire

// File: verif/acl_gpio_status_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module acl_gpio_status_tb_top
    import acl_pkg::*;
;
    logic clock_i = 0, link_clk_i = 0, resetn_i = 0, go = 0, msr_wr_i = 0, msr_rd_i = 0, io_wr_i = 0;
    logic io_rd_i = 0, link_shutdown_set_i = 0, other_irq_i = 0, bad_type_event_i = 0;
    logic [7:0] io_addr_i = '0;
    logic [31:0] msr_addr_i = '0, io_wdata_i = '0, io_rdata_o;
    logic [63:0] msr_wdata_i = '0, msr_rdata_o;
    logic [255:0] frame = '0;
    logic irq_o, sync_mgmt_trap_o, error_o, local_bus_clk_off_o, interconnect_clk_off_o, out_slot12_valid_o;
    wire logic sync_i, serial_in_primary_i, serial_in_secondary_i;
    logic [19:0] out_slot12_data_o;
    logic [3:0] bm5_rx_slot_o, bm4_tx_slot_o;
    int errors = 0, compares = 0, cycles = 0;
    always #20 clock_i = ~clock_i;
    initial #1.7 forever #3 link_clk_i = ~link_clk_i; // unrelated phase
    // one stream for both codecs
    assign serial_in_secondary_i = serial_in_primary_i;
    acl_gpio_status acl_gpio_status_i (.*, .codecs_powered_down_i(1'b0), .resp_valid_i(1'b0),
        .exception_bit_i(1'b0), .local_bus_idle_i(1'b1), .interconnect_idle_i(1'b1));
    acl_codec_model acl_codec_model_i (.link_clk_i, .go_i(go), .frame_i(frame), .sync_o(sync_i),
        .sdata_o(serial_in_primary_i));
    task automatic check(input logic [63:0] seen, exp, input string what);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // read compares d
    task automatic io(input bit wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        {io_wr_i, io_rd_i, io_addr_i, io_wdata_i} <= {wr, !wr, a, d};
        @(posedge clock_i);
        {io_wr_i, io_rd_i} <= 2'b00;
        @(negedge clock_i);
        if (!wr)
            check(io_rdata_o, d, "io");
    endtask
    task automatic msr(input bit wr, input logic [31:0] a, input logic [63:0] d);
        @(posedge clock_i);
        {msr_wr_i, msr_rd_i, msr_addr_i, msr_wdata_i} <= {wr, !wr, a, d};
        @(posedge clock_i);
        {msr_wr_i, msr_rd_i} <= 2'b00;
        @(negedge clock_i);
        if (!wr)
            check(msr_rdata_o, d, "msr");
    endtask
    task automatic complete_run;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // hang guard
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            complete_run();
        end
    end
    initial begin
        repeat (12) @(posedge clock_i);
        resetn_i <= 1;
        // reset values
        for (int i = 2; i < 7; i++) msr(0, 32'h51500000 + 32'(i), 0);
        for (int i = 0; i < 16; i += 4) io(0, 8'(i), 0);
        io(1, ACL_IO_GPIO_DRIVE, 32'hFFFFFFFF);
        io(0, ACL_IO_GPIO_DRIVE, 32'h000FFFFF);
        check(out_slot12_data_o, 0, "slot12");
        io(1, ACL_IO_LINK_STATE, 32'h00380000);
        check({bm5_rx_slot_o, bm4_tx_slot_o}, 8'hBB, "slots");
        io(1, ACL_IO_LINK_STATE, 32'h00200000);
        check({bm5_rx_slot_o, bm4_tx_slot_o}, 8'h66, "slots");
        msr(1, ACL_MSR_TRAP_ADDR, 64'h1);
        msr(1, ACL_MSR_ERROR_ADDR, 64'h1);
        io(1, ACL_IO_GPIO_STATE, 32'hC0000000);
        check({out_slot12_valid_o, out_slot12_data_o}, 21'h1FFFFF, "slot12");
        // one frame
        frame <= {16'hE008, 20'hA5000, 20'h12345, 180'h0, 20'hABCD1};
        go <= 1;
        repeat (2) @(posedge clock_i);
        go <= 0;
        repeat (50) @(posedge clock_i);
        check(irq_o, 1, "irq");
        io(0, ACL_IO_LINK_STATE, 32'hA5E21234);
        io(0, ACL_IO_LINK_STATE, 32'hA5E01234);
        io(0, ACL_IO_GPIO_STATE, 32'hC02ABCD1);
        io(0, ACL_IO_GPIO_STATE, 32'hC00ABCD1);
        check(irq_o, 0, "irq");
        msr(0, ACL_MSR_TRAP_ADDR, 64'h100000001);
        msr(1, ACL_MSR_TRAP_ADDR, 64'h1);
        msr(0, ACL_MSR_TRAP_ADDR, 64'h100000001);
        msr(1, ACL_MSR_TRAP_ADDR, 64'h100000001);
        msr(0, ACL_MSR_TRAP_ADDR, 64'h1);
        @(posedge clock_i);
        {link_shutdown_set_i, bad_type_event_i, other_irq_i} <= 3'b111;
        @(posedge clock_i);
        {link_shutdown_set_i, bad_type_event_i} <= 2'b00;
        io(0, ACL_IO_LINK_STATE, 32'hA5201234);
        msr(0, ACL_MSR_ERROR_ADDR, 64'h100000001);
        msr(1, ACL_MSR_CLKGATE_ADDR, 64'h5);
        check({local_bus_clk_off_o, interconnect_clk_off_o}, 2'b11, "gate");
        msr(0, ACL_MSR_CLKGATE_ADDR, 64'h5);
        complete_run();
    end
endmodule
`default_nettype wire
